// ### core/sysref_pkg.sv
package sysref_pkg;

    // -------------------------------------------------------------------------
    // Field widths.
    // -------------------------------------------------------------------------
    localparam int DIV_FIELD_W = 7;  // Release divider field width.
    localparam int SUB_FIELD_W = 3;  // Width of each three-bit divider sub-field.
    localparam int RATIO_W = 8;      // Release ratio width; largest ratio is 16 x 9 = 144.
    localparam int COUNT_W = 8;      // Pulse-count field width.
    localparam int DELAY_W = 8;      // Global phase delay field width.

    // -------------------------------------------------------------------------
    // Field positions inside the release divider field.
    // -------------------------------------------------------------------------
    localparam int DIV_LOWER_LSB = 0;  // Lower ratio field starts at bit 0.
    localparam int DIV_UPPER_LSB = 3;  // Upper ratio field starts at bit 3.
    localparam int DIV_MODE_BIT = 6;   // Mode bit selecting lower-only or product.

    // -------------------------------------------------------------------------
    // Reset values.
    // -------------------------------------------------------------------------
    localparam logic [DIV_FIELD_W-1:0] DIV_RESET = 7'h01;    // Release divider reset value.
    localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h02;      // Pulse count reset value.
    localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;      // Global delay reset value.
    localparam logic SOURCE_RESET = 1'b0;                    // Software trigger after reset.
    localparam logic MODE_RESET = 1'b0;                      // Counted mode after reset.
    localparam logic BIAS_TYPE_RESET = 1'b1;                 // Cross-point bias after reset.

    // -------------------------------------------------------------------------
    // Encodings and ratio tables.
    // -------------------------------------------------------------------------
    localparam logic SRC_SOFTWARE = 1'b0;   // Request bit triggers the burst.
    localparam logic SRC_EXTERNAL = 1'b1;   // External trigger pin triggers the burst.
    localparam logic MODE_COUNTED = 1'b0;   // Counted burst.
    localparam logic MODE_CONTINUOUS = 1'b1;  // Continuous stream.
    localparam logic [RATIO_W-1:0] LOWER_RATIO_OFFSET = 8'h02;  // Lower field ratio is field plus this.
    localparam logic [RATIO_W-1:0] UPPER_RATIO_TABLE [8] = '{
        8'h02, 8'h04, 8'h06, 8'h08, 8'h04, 8'h08, 8'h0C, 8'h10
    };  // Upper field ratios for codes 000 to 111.

    // -------------------------------------------------------------------------
    // Timing.
    // -------------------------------------------------------------------------
    localparam int DELAY_STEP_PS = 407;  // Analog delay added per global delay step.

    // Burst sequencer states, Gray coded along idle, armed, wait, run.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_WAIT = 2'b11,
        ST_RUN = 2'b10
    } burst_state_e;

endpackage

// ### core/sysref_release_timer.sv
`timescale 1ns/10ps

// -----------------------------------------------------------------------------
// Release timer: decodes the release divider and counts the release period.
// -----------------------------------------------------------------------------
module sysref_release_timer
    import sysref_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [DIV_FIELD_W-1:0] div_field,
    output logic [RATIO_W-1:0] ratio,
    output logic [RATIO_W-1:0] phase,
    output logic tick
);

    logic [RATIO_W-1:0] lower_ratio;  // Ratio of the lower field.
    logic [RATIO_W-1:0] upper_ratio;  // Ratio of the upper field.
    logic [2*RATIO_W-1:0] product;    // Full-width product of both ratios.
    logic [RATIO_W-1:0] phase_ff;     // Position inside the release period.
    logic [RATIO_W-1:0] nxt_phase;    // Next period position.

    // Decode both sub-fields and pick the release ratio by the mode bit.
    always_comb begin
        lower_ratio = LOWER_RATIO_OFFSET + RATIO_W'(div_field[DIV_LOWER_LSB +: SUB_FIELD_W]);
        upper_ratio = UPPER_RATIO_TABLE[div_field[DIV_UPPER_LSB +: SUB_FIELD_W]];
        product = upper_ratio * lower_ratio;
        if (div_field[DIV_MODE_BIT]) begin
            // The product never passes 144, so the low byte holds it whole.
            ratio = product[RATIO_W-1:0];
        end else begin
            ratio = lower_ratio;
        end
    end

    // The period counter runs freely so that every release lands on coincident edges.
    always_comb begin
        tick = (phase_ff >= ratio - 8'h01);
        if (tick) begin
            nxt_phase = 8'h00;
        end else begin
            nxt_phase = phase_ff + 8'h01;
        end
    end

    // Register the period position.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= 8'h00;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase = phase_ff;

endmodule // sysref_release_timer

// ### core/sysref_pulse_generator.sv
// Contract
// - Release pulses only on coincident release edges.
// - Upper field ratios: 2,4,6,8,4,8,12,16.
// - Mode bit: lower only, or upper times lower.
// - Counted burst emits pulse-count field pulses.
// - Global delay is steps of 407 ps.
// - Source bit picks software or external trigger.
// - Mode bit picks counted or continuous.
// - Request powers up and releases pulses.
// - Request aligns outputs and applies delay.
// - Request self-clears in counted mode.
// - Each software request starts one burst.
// - External mode: arm, then next rising edge.
// - Bias type sets output state during event.
`timescale 1ns/10ps

module sysref_pulse_generator
    import sysref_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [DIV_FIELD_W-1:0] sysref_release_divider,
    input wire logic [COUNT_W-1:0] pulse_count_field,
    input wire logic [DELAY_W-1:0] sysref_global_phase_delay,
    input wire logic source_select_bit,
    input wire logic pulse_mode_bit,
    input wire logic bias_type,
    input wire logic request_bit_write,
    input wire logic external_trigger_pin,
    output logic reference_output,
    output logic reference_output_bias_enable,
    output logic bias_crosspoint,
    output logic sysref_powered,
    output logic align_strobe,
    output logic [DELAY_W-1:0] applied_delay,
    output logic request_bit
);

    // -------------------------------------------------------------------------
    // Release timer.
    // -------------------------------------------------------------------------
    logic [RATIO_W-1:0] ratio;  // Current release ratio.
    logic [RATIO_W-1:0] phase;  // Position inside the release period.
    logic tick;                 // Last cycle of the release period.

    sysref_release_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .div_field(sysref_release_divider),
        .ratio(ratio),
        .phase(phase),
        .tick(tick)
    );

    // -------------------------------------------------------------------------
    // External trigger synchroniser and edge detect.
    // -------------------------------------------------------------------------
    logic ext_meta_ff;  // First synchroniser stage, read only by the second.
    logic ext_sync_ff;  // Second synchroniser stage.
    logic ext_prev_ff;  // Previous synchronised level for edge detection.
    logic ext_rise;     // Rising edge of the synchronised trigger.

    // Two flops bring the pin into the output clock domain before any edge logic.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_meta_ff <= external_trigger_pin;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    assign ext_rise = ext_sync_ff & ~ext_prev_ff;

    // -------------------------------------------------------------------------
    // Burst sequencer.
    // -------------------------------------------------------------------------
    burst_state_e state_ff;              // Sequencer state.
    burst_state_e nxt_state;             // Next sequencer state.
    logic [COUNT_W-1:0] remaining_ff;    // Pulses still to release.
    logic [COUNT_W-1:0] nxt_remaining;   // Next remaining count.
    logic run_cont_ff;                   // Current run is continuous.
    logic nxt_run_cont;                  // Next continuous flag.
    logic pending_ff;                    // Readback of the request bit.
    logic nxt_pending;                   // Next request readback.

    // Compute the next sequencer state, pulse budget and request readback.
    always_comb begin
        nxt_state = state_ff;
        nxt_remaining = remaining_ff;
        nxt_run_cont = run_cont_ff;
        nxt_pending = pending_ff;
        if (request_bit_write) begin
            // Every request re-arms and drops any burst under way; the new burst starts once the source fires.
            nxt_state = ST_ARMED;
            nxt_pending = 1'b1;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_ARMED: begin
                    // Software source fires at once; external waits for the edge.
                    if (source_select_bit == SRC_SOFTWARE) begin
                        nxt_state = ST_WAIT;
                    end else if (ext_rise) begin
                        nxt_state = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // The run starts only at a release boundary.
                    if (tick) begin
                        nxt_run_cont = (pulse_mode_bit == MODE_CONTINUOUS);
                        nxt_remaining = pulse_count_field;
                        if (pulse_mode_bit == MODE_COUNTED && pulse_count_field == 8'h00) begin
                            nxt_state = ST_IDLE;
                            nxt_pending = 1'b0;
                        end else begin
                            nxt_state = ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        if (run_cont_ff) begin
                            // A continuous stream ends when the mode bit is cleared.
                            if (pulse_mode_bit == MODE_COUNTED) begin
                                nxt_state = ST_IDLE;
                                nxt_pending = 1'b0;
                            end
                        end else if (remaining_ff <= 8'h01) begin
                            nxt_state = ST_IDLE;
                            nxt_remaining = 8'h00;
                            nxt_pending = 1'b0;
                        end else begin
                            nxt_remaining = remaining_ff - 8'h01;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // Register the sequencer.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            remaining_ff <= 8'h00;
            run_cont_ff <= 1'b0;
            pending_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            remaining_ff <= nxt_remaining;
            run_cont_ff <= nxt_run_cont;
            pending_ff <= nxt_pending;
        end
    end

    // -------------------------------------------------------------------------
    // Output stage.
    // -------------------------------------------------------------------------
    logic ref_ff;                  // Reference output level.
    logic nxt_ref;                 // Next reference level.
    logic bias_en_ff;              // Bias hold active while an event is under way.
    logic nxt_bias_en;             // Next bias hold.
    logic cross_ff;                // Hold state is cross-point rather than low/high.
    logic nxt_cross;               // Next hold state.
    logic power_ff;                // Reference circuitry powered.
    logic nxt_power;               // Next power state.
    logic align_ff;                // One-cycle phase alignment strobe.
    logic nxt_align;               // Next alignment strobe.
    logic [DELAY_W-1:0] delay_ff;  // Delay loaded into the reference paths.
    logic [DELAY_W-1:0] nxt_delay; // Next applied delay.

    // Each pulse is high for the first half of its release period.
    always_comb begin
        nxt_ref = (state_ff == ST_RUN) && (phase < (ratio >> 1));
        nxt_power = (nxt_state != ST_IDLE);
        nxt_bias_en = (state_ff != ST_IDLE);
        nxt_cross = bias_type;
        nxt_align = request_bit_write;
        // Each step adds DELAY_STEP_PS in the analog delay line fed by this value.
        nxt_delay = request_bit_write ? sysref_global_phase_delay : delay_ff;
    end

    // Register the outputs.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_ff <= 1'b0;
            bias_en_ff <= 1'b0;
            cross_ff <= BIAS_TYPE_RESET;
            power_ff <= 1'b0;
            align_ff <= 1'b0;
            delay_ff <= DELAY_RESET;
        end else begin
            ref_ff <= nxt_ref;
            bias_en_ff <= nxt_bias_en;
            cross_ff <= nxt_cross;
            power_ff <= nxt_power;
            align_ff <= nxt_align;
            delay_ff <= nxt_delay;
        end
    end

    assign reference_output = ref_ff;
    assign reference_output_bias_enable = bias_en_ff;
    assign bias_crosspoint = cross_ff;
    assign sysref_powered = power_ff;
    assign align_strobe = align_ff;
    assign applied_delay = delay_ff;
    assign request_bit = pending_ff;

    // -------------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------------
    property p_pulse_on_boundary;
        @(posedge clk) disable iff (!rst_b)
        $rose(ref_ff) |-> ($past(phase) == 8'h00) && ($past(state_ff) == ST_RUN);
    endproperty
    a_pulse_on_boundary: assert property (p_pulse_on_boundary) else $error("pulse off boundary");

    property p_upper_ratio;
        @(posedge clk) disable iff (!rst_b)
        (sysref_release_divider[6:3] == 4'hE) |-> (ratio == 8'(8'h0C * (8'h02 + 8'(sysref_release_divider[2:0]))));
    endproperty
    a_upper_ratio: assert property (p_upper_ratio) else $error("upper ratio 110 wrong");

    property p_lower_only;
        @(posedge clk) disable iff (!rst_b)
        !sysref_release_divider[DIV_MODE_BIT] |-> (ratio == 8'h02 + 8'(sysref_release_divider[2:0]));
    endproperty
    a_lower_only: assert property (p_lower_only) else $error("lower-only ratio wrong");

    property p_counted_end;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == ST_RUN) && tick && !run_cont_ff && (remaining_ff == 8'h01) && !request_bit_write
        |=> (state_ff == ST_IDLE) && !pending_ff;
    endproperty
    a_counted_end: assert property (p_counted_end) else $error("counted burst did not end");

    property p_request_applies;
        @(posedge clk) disable iff (!rst_b)
        request_bit_write |=> align_ff && (delay_ff == $past(sysref_global_phase_delay)) && power_ff;
    endproperty
    a_request_applies: assert property (p_request_applies) else $error("request not applied");

    property p_external_waits;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == ST_ARMED) && (source_select_bit == SRC_EXTERNAL) && !ext_rise && !request_bit_write
        |=> (state_ff == ST_ARMED);
    endproperty
    a_external_waits: assert property (p_external_waits) else $error("left armed without edge");

    property p_software_fires;
        @(posedge clk) disable iff (!rst_b)
        request_bit_write && (source_select_bit == SRC_SOFTWARE) ##1 !request_bit_write
        |=> (state_ff == ST_WAIT);
    endproperty
    a_software_fires: assert property (p_software_fires) else $error("software request stalled");

    property p_continuous_holds;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == ST_RUN) && run_cont_ff && (pulse_mode_bit == MODE_CONTINUOUS) && !request_bit_write
        |=> (state_ff == ST_RUN) && pending_ff;
    endproperty
    a_continuous_holds: assert property (p_continuous_holds) else $error("continuous run stopped");

    property p_bias_follows;
        @(posedge clk) disable iff (!rst_b)
        (state_ff != ST_IDLE) |=> bias_en_ff && (cross_ff == $past(bias_type));
    endproperty
    a_bias_follows: assert property (p_bias_follows) else $error("bias hold wrong");

endmodule // sysref_pulse_generator

// ### tb/sysref_converter_model.sv
`timescale 1ns/10ps

// -----------------------------------------------------------------------------
// Far side: a converter that receives the reference pulses, and a trigger source.
// -----------------------------------------------------------------------------
module sysref_converter_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reference_output,
    input wire logic fire,
    input wire logic clear,
    output logic external_trigger_pin,
    output logic [15:0] pulse_cnt,
    output logic [15:0] last_period,
    output logic [15:0] last_width
);
    logic prev_ff;  // Reference level at the previous edge.
    logic [15:0] since_ff;  // Cycles since the last rising edge.
    logic [15:0] high_ff;  // Cycles the current pulse has been high.

    // The trigger source idles low and fires off the clock grid, so the pin is truly asynchronous.
    initial external_trigger_pin = 1'b0;
    always @(posedge fire) begin
        #7;
        external_trigger_pin = 1'b1;
        #53;
        external_trigger_pin = 1'b0;
    end

    // The receiver counts pulses and measures the period and the high time of each one.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b || clear) begin
            prev_ff <= 1'b0;
            since_ff <= 16'h0000;
            high_ff <= 16'h0000;
            pulse_cnt <= 16'h0000;
            last_period <= 16'h0000;
            last_width <= 16'h0000;
        end else begin
            prev_ff <= reference_output;
            since_ff <= since_ff + 16'h0001;
            high_ff <= reference_output ? high_ff + 16'h0001 : 16'h0000;
            if (reference_output && !prev_ff) begin
                pulse_cnt <= pulse_cnt + 16'h0001;
                last_period <= since_ff;
                since_ff <= 16'h0001;
            end
            if (!reference_output && prev_ff) begin
                last_width <= high_ff;
            end
        end
    end
endmodule  // sysref_converter_model

// ### tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    import sysref_pkg::*;

    // -------------------------------------------------------------------------
    // Signals.
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] pulses;
        logic [RATIO_W-1:0] ratio;
        logic [DELAY_W-1:0] delay;
        logic bias;
    } expect_s;  // One note per burst that should complete.
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [DIV_FIELD_W-1:0] div = 7'h01;
    logic [COUNT_W-1:0] cnt = 8'h02;
    logic [DELAY_W-1:0] dly = 8'h00;
    logic src = 1'b0;
    logic mode = 1'b0;
    logic bias = 1'b1;
    logic req = 1'b0;
    logic fire = 1'b0;
    logic clear = 1'b0;
    logic ext_pin, ref_out, bias_en, bias_cp, powered, align, req_bit;
    logic req_prev = 1'b0;  // Request readback one cycle earlier.
    logic [DELAY_W-1:0] applied;
    logic [15:0] pulse_cnt, last_period, last_width;
    logic [31:0] seed = 32'h0b31_2191;  // Xorshift state.
    expect_s q[$];  // Notes of expected bursts, oldest first.
    expect_s e_mon;  // Note taken off by the monitor.
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    sysref_pulse_generator i_dut (
        .clk(clk), .rst_b(rst_b), .sysref_release_divider(div), .pulse_count_field(cnt),
        .sysref_global_phase_delay(dly), .source_select_bit(src), .pulse_mode_bit(mode),
        .bias_type(bias), .request_bit_write(req), .external_trigger_pin(ext_pin),
        .reference_output(ref_out), .reference_output_bias_enable(bias_en), .bias_crosspoint(bias_cp),
        .sysref_powered(powered), .align_strobe(align), .applied_delay(applied), .request_bit(req_bit)
    );

    sysref_converter_model i_far (
        .clk(clk), .rst_b(rst_b), .reference_output(ref_out), .fire(fire), .clear(clear),
        .external_trigger_pin(ext_pin), .pulse_cnt(pulse_cnt), .last_period(last_period),
        .last_width(last_width)
    );

    // -------------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // The release ratio is the lower ratio alone, or the upper ratio times the lower one.
    function automatic logic [RATIO_W-1:0] ratio_of(input logic [DIV_FIELD_W-1:0] d);
        logic [RATIO_W-1:0] lo;
        lo = RATIO_W'(d[2:0]) + LOWER_RATIO_OFFSET;
        return d[DIV_MODE_BIT] ? RATIO_W'(UPPER_RATIO_TABLE[d[5:3]] * lo) : lo;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks made: %0d, mismatches: %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One software write of the request bit, with a note if a completed burst is expected.
    task automatic burst(input logic [DIV_FIELD_W-1:0] d, input logic [COUNT_W-1:0] c,
                         input logic [15:0] n, input logic note);
        expect_s e;
        div = d;
        cnt = c;
        dly = DELAY_W'(rnd() >> 8);
        bias = 1'(rnd() >> 3);
        req = 1'b1;
        clear = 1'b1;
        e = '{pulses: n, ratio: ratio_of(d), delay: dly, bias: bias};
        if (note) begin
            q.push_back(e);
        end
        @(negedge clk);
        req = 1'b0;
        clear = 1'b0;
        check(16'({align, req_bit, powered}), 16'h0007, "request answer");
        check(16'(applied), 16'(e.delay), "latched delay");
        dly = ~dly;
        @(negedge clk);
        check(16'(align), 16'h0000, "strobe length");
    endtask

    // Waits for the request readback to clear, then expects the block idle.
    task automatic wait_done();
        int k;
        for (k = 0; k < 2000 && req_bit !== 1'b0; k++) begin
            @(negedge clk);
        end
        check(16'(k < 2000), 16'h0001, "burst end");
        repeat (3) @(negedge clk);
        check(16'({powered, bias_en, ref_out}), 16'h0000, "idle after burst");
    endtask

    // -------------------------------------------------------------------------
    // Monitor: compares each finished burst with the oldest note.
    // -------------------------------------------------------------------------
    always @(negedge clk) begin
        if (ref_out === 1'b1) begin
            check(16'({bias_en, powered}), 16'h0003, "event flags");
        end
        if (req_prev === 1'b1 && req_bit === 1'b0) begin
            if (q.size() == 0) begin
                check(16'h0001, 16'h0000, "unexpected burst end");
            end else begin
                e_mon = q.pop_front();
                check(pulse_cnt, e_mon.pulses, "pulse count");
                if (e_mon.pulses > 1) check(last_period, 16'(e_mon.ratio), "period");
                if (e_mon.pulses > 0) check(last_width, 16'(e_mon.ratio >> 1), "width");
                check(16'(applied), 16'(e_mon.delay), "applied delay");
                check(16'(bias_cp), 16'(e_mon.bias), "bias kind");
            end
        end
        req_prev = req_bit;
    end

    // A hang is cut short well beyond the longest expected run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            stop_test();
        end
    end

    // -------------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(16'({req_bit, powered, ref_out, bias_en, bias_cp}), 16'h0001, "reset outputs");
        check(16'(applied), 16'(DELAY_RESET), "reset delay");
        for (int l = 0; l < 8; l++) begin
            r = rnd();
            burst({1'b0, r[2:0], 3'(l)}, 8'h02, 16'h0002, 1'b1);
            wait_done();
        end
        for (int u = 0; u < 8; u++) begin
            r = rnd();
            burst({1'b1, 3'(u), r[2:0]}, 8'h03, 16'h0003, 1'b1);
            wait_done();
        end
        burst(7'h00, 8'h00, 16'h0000, 1'b1);
        wait_done();
        burst(7'h00, 8'hff, 16'h00ff, 1'b1);
        wait_done();
        burst(7'h01, 8'h04, 16'h0000, 1'b0);
        burst(7'h01, 8'h04, 16'h0004, 1'b1);
        wait_done();
        src = 1'b1;
        burst(7'h02, 8'h02, 16'h0002, 1'b1);
        repeat (30) @(negedge clk);
        check(16'({pulse_cnt[7:0], req_bit}), 16'h0001, "armed without pulses");
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        wait_done();
        src = 1'b0;
        mode = 1'b1;
        burst(7'h04, 8'h02, 16'h0005, 1'b1);
        for (int k = 0; k < 200 && pulse_cnt !== 16'h0005; k++) begin
            @(negedge clk);
        end
        mode = 1'b0;
        wait_done();
        stop_test();
    end
endmodule  // testbench
